// ==== hw/spi_pkg.sv ====
// constants and types of the serial port
package spi_pkg;
    localparam int          DATA_W      = 8;
    localparam int          FIFO_DEPTH  = 8;
    // bus clock 100 MHz, period in ns
    localparam int          CLK_NS      = 10;
    // half bit periods in bus cycles for each rate code
    localparam logic [6:0]  HALF_BY2    = 7'h01;
    localparam logic [6:0]  HALF_BY8    = 7'h04;
    localparam logic [6:0]  HALF_BY32   = 7'h10;
    localparam logic [6:0]  HALF_BY128  = 7'h40;
    localparam logic [1:0]  RATE_BY2    = 2'h0;
    localparam logic [1:0]  RATE_BY8    = 2'h1;
    localparam logic [1:0]  RATE_BY32   = 2'h2;
    localparam logic [6:0]  DIV_RST     = 7'h00;
    localparam logic [3:0]  LAST_EDGE   = 4'hF;
    localparam logic [3:0]  EDGE_RST    = 4'h0;
    localparam logic [7:0]  SHIFT_RST   = 8'h00;
    localparam logic [7:0]  RX_RST      = 8'h00;
    localparam logic [3:0]  SYNC_RST    = 4'hF;
    localparam logic [2:0]  LAST_BIT    = 3'h7;
    localparam logic [2:0]  BIT_RST     = 3'h0;
    typedef enum logic
    {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } xfer_state_t;
endpackage

// ==== hw/tx_fifo_if.sv ====
// valid/ready link between the transmit buffer and the port
`timescale 1ns/10ps
interface tx_fifo_if;
    logic [7:0] wdata;
    logic       wvalid;
    logic       wready;
    logic [7:0] rdata;
    logic       rvalid;
    logic       rready;
    modport buffer
    (
        input  wdata, wvalid, rready,
        output wready, rdata, rvalid
    );
    modport user
    (
        output wdata, wvalid, rready,
        input  wready, rdata, rvalid
    );
endinterface

// ==== hw/tx_fifo.sv ====
// flip-flop fifo holding transmit bytes
`timescale 1ns/10ps
module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    tx_fifo_if.buffer f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             room_q;
    logic             push;
    logic             pop;

    assign push    = f.wvalid & room_q;
    assign pop     = f.rready & (cnt_q != '0);
    assign cnt_d   = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign f.wready = room_q;
    assign f.rvalid = (cnt_q != '0);
    assign f.rdata  = mem_q[rd_q];

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= f.wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wr_q   <= '0;
            rd_q   <= '0;
            cnt_q  <= '0;
            room_q <= 1'b1;
        end
        else
        begin
            wr_q   <= push ? AW'(wr_q + 1'b1) : wr_q;
            rd_q   <= pop ? AW'(rd_q + 1'b1) : rd_q;
            cnt_q  <= cnt_d;
            room_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule

// ==== hw/spi_port.sv ====
// serial port: master/slave shifter, rate divider, error flags
`timescale 1ns/10ps
// Operation
// - polarity sets idle level, phase selects format
// - slave drives data out only when selected
// - phase 0: first edge samples, select starts
// - phase 0 slave: select fall presents top bit
// - no shift reload mid-transfer; byte waits
// - phase 1: first clock edge starts transfer
// - phase 1 slave: first edge presents top bit
// - master write of data starts transfer
// - master first half-bit idle or opening edge
// - divider runs only when enabled and master
// - clock edges aligned to bus clock
// - master start delay at most one bit
// - unread data at first sample sets overflow
// - error enable routes overflow and fault to irq
// - fault flag never sets while fault disabled
// - fault when select contradicts role
// - overflow masks further receive interrupts
// - receive full clears: status then data read
// - master select bit picks master or slave
// - rate bits set master shift speed
module spi_port (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       port_enable_bit,
    input  wire logic       master_select_bit,
    input  wire logic       clk_polarity_bit,
    input  wire logic       clk_phase_bit,
    input  wire logic       rate_select_hi,
    input  wire logic       rate_select_lo,
    input  wire logic       select_fault_enable,
    input  wire logic       error_irq_enable,
    input  wire logic       rx_irq_enable,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       status_read,
    input  wire logic       data_read,
    input  wire logic       control_write,
    output logic [7:0]      rx_data,
    output logic            rx_full_flag,
    output logic            overflow_flag,
    output logic            select_fault_flag,
    output logic            tx_empty_flag,
    output logic            rx_err_irq,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    input  wire logic       ss_n_in
);
    localparam int LAT_MAX = 128;

    tx_fifo_if            txq ();
    spi_pkg::xfer_state_t st_q;
    spi_pkg::xfer_state_t st_d;
    logic [3:0]           pins;
    logic [3:0]           s1_q;
    logic [3:0]           s2_q;
    logic [3:0]           s3_q;
    logic [6:0]           div_q;
    logic [6:0]           half;
    logic [3:0]           e_q;
    logic [7:0]           sh_q;
    logic [7:0]           sh_d;
    logic [7:0]           rx_byte;
    logic [1:0]           rate;
    logic [1:0]           mcap_q;
    logic [2:0]           rcnt_q;
    logic [7:0]           rsh_q;
    logic                 cap_q, sck_q, dout_q, rd_arm_q, flt_arm_q, ld_q;
    logic                 en, mst, slv, din, sck_s, sck_p, ss_s, ss_p;
    logic                 tick, slv_edge, ss_fall, slv_start, mst_start, start;
    logic                 edge_ev, samp, last, first_samp, abort, pop;
    logic                 mst_fault, slv_fault, fault_set, deliver, ovf_set, cap_ev, rx_done;

    tx_fifo #(
        .WIDTH (spi_pkg::DATA_W),
        .DEPTH (spi_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk (clk),
        .rst (rst),
        .f   (txq.buffer)
    );

    assign txq.wdata  = tx_data;
    assign txq.wvalid = tx_valid;
    assign txq.rready = pop;
    assign tx_ready   = txq.wready;

    // two-stage synchronisers, third stage for edge finding
    assign pins = {ss_n_in, serial_clock_pin_in, mosi_in, miso_in};
    for (genvar i = 0; i < 4; i++)
    begin : g_sync
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                s1_q[i] <= spi_pkg::SYNC_RST[i];
                s2_q[i] <= spi_pkg::SYNC_RST[i];
                s3_q[i] <= spi_pkg::SYNC_RST[i];
            end
            else
            begin
                s1_q[i] <= pins[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
            end
        end
    end

    assign en    = port_enable_bit;
    assign mst   = master_select_bit;
    assign slv   = en & ~mst;
    assign ss_s  = s2_q[3];
    assign ss_p  = s3_q[3];
    assign sck_s = s2_q[2];
    assign sck_p = s3_q[2];
    assign din   = mst ? s2_q[0] : s2_q[1];

    // rate code to half bit period
    assign rate = {rate_select_hi, rate_select_lo};
    assign half = (rate == spi_pkg::RATE_BY2)  ? spi_pkg::HALF_BY2  :
                  (rate == spi_pkg::RATE_BY8)  ? spi_pkg::HALF_BY8  :
                  (rate == spi_pkg::RATE_BY32) ? spi_pkg::HALF_BY32 :
                                                 spi_pkg::HALF_BY128;
    // edges land on bus clock edges, one tick per half bit
    assign tick = en & mst & (div_q == 7'(half - 7'h01));

    always_ff @(posedge clk)
    begin
        if (rst | ~(en & mst))
            div_q <= spi_pkg::DIV_RST;
        else
            div_q <= tick ? spi_pkg::DIV_RST : 7'(div_q + 7'h01);
    end

    // start events
    assign slv_edge  = slv & ~ss_s & (sck_s != sck_p);
    assign ss_fall   = slv & ~ss_s & ss_p;
    assign slv_start = (st_q == spi_pkg::ST_IDLE) &
                       (clk_phase_bit ? (slv_edge & (sck_p == clk_polarity_bit))
                                      : ss_fall);
    // start on any tick: first edge one tick later keeps delay within a bit
    assign mst_start = (st_q == spi_pkg::ST_IDLE) & tick & txq.rvalid
                     & ~select_fault_flag;
    assign start     = mst_start | slv_start;
    assign pop       = (st_q == spi_pkg::ST_IDLE) & txq.rvalid
                     & (mst ? mst_start : (slv & ~ld_q));

    // edge engine shared by master ticks and slave clock edges
    assign edge_ev    = ((st_q == spi_pkg::ST_SHIFT) & (mst ? tick : slv_edge))
                      | (slv_start & clk_phase_bit);
    assign samp       = (e_q[0] == clk_phase_bit);
    assign last       = edge_ev & (e_q == spi_pkg::LAST_EDGE);
    assign first_samp = edge_ev & samp & (e_q == {3'h0, clk_phase_bit});
    assign rx_byte    = {rsh_q[6:0], din};
    assign cap_ev     = mst ? mcap_q[1] : (edge_ev & samp); // master lags two sync cycles
    assign rx_done    = cap_ev & (rcnt_q == spi_pkg::LAST_BIT);

    // mode faults
    assign mst_fault = en & mst & ~ss_s;
    assign slv_fault = slv & ss_s & (st_q == spi_pkg::ST_SHIFT);
    assign fault_set = select_fault_enable & (mst_fault | slv_fault);
    assign abort     = (st_q == spi_pkg::ST_SHIFT) & (~en | slv_fault | fault_set);

    assign ovf_set = (first_samp | rx_done) & rx_full_flag;
    assign deliver = rx_done & ~rx_full_flag & ~overflow_flag;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            spi_pkg::ST_IDLE:
                if (start & en)
                    st_d = spi_pkg::ST_SHIFT;
            spi_pkg::ST_SHIFT:
                if (abort | last)
                    st_d = spi_pkg::ST_IDLE;
            default:
                st_d = spi_pkg::ST_IDLE;
        endcase
    end

    // shift register: load only while idle, shift on output edges
    assign sh_d = ~en ? spi_pkg::SHIFT_RST :
                  pop ? txq.rdata :
                  (edge_ev & ~samp & (e_q != spi_pkg::EDGE_RST)) ?
                        {sh_q[6:0], cap_q} : sh_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_q   <= spi_pkg::ST_IDLE;
            e_q    <= spi_pkg::EDGE_RST;
            sh_q   <= spi_pkg::SHIFT_RST;
            cap_q  <= 1'b0;
            dout_q <= 1'b0;
            mcap_q <= 2'h0;
            rcnt_q <= spi_pkg::BIT_RST;
            ld_q   <= 1'b0;
        end
        else
        begin
            st_q   <= st_d;
            e_q    <= (st_d == spi_pkg::ST_IDLE) ? spi_pkg::EDGE_RST :
                      edge_ev ? 4'(e_q + 4'h1) : e_q;
            sh_q   <= sh_d;
            cap_q  <= (edge_ev & samp) ? din : cap_q;
            dout_q <= sh_d[7];
            mcap_q <= (en & ~abort) ? {mcap_q[0], mst & edge_ev & samp} : 2'h0;
            rcnt_q <= (~en | abort) ? spi_pkg::BIT_RST : cap_ev ? 3'(rcnt_q + 3'h1) : rcnt_q;
            rsh_q  <= cap_ev ? {rsh_q[6:0], din} : rsh_q;
            ld_q   <= en & (pop | (ld_q & ~last & ~abort));
        end
    end

    // pin drivers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sck_q        <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
            mosi_oe      <= 1'b0;
            miso_oe      <= 1'b0;
        end
        else
        begin
            sck_q        <= ((st_q == spi_pkg::ST_IDLE) | abort) ? clk_polarity_bit :
                            edge_ev ? ~sck_q : sck_q;
            serial_clock_pin_oe <= en & mst;
            mosi_oe      <= en & mst;
            miso_oe      <= slv & ~ss_s;
        end
    end

    assign serial_clock_pin_out = sck_q;
    assign mosi_out = dout_q;
    assign miso_out = dout_q;

    // status flags, set wins over clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_full_flag      <= 1'b0;
            overflow_flag     <= 1'b0;
            select_fault_flag <= 1'b0;
            rd_arm_q          <= 1'b0;
            flt_arm_q         <= 1'b0;
            rx_data           <= spi_pkg::RX_RST;
            tx_empty_flag     <= 1'b1;
            rx_err_irq        <= 1'b0;
        end
        else
        begin
            rx_full_flag  <= deliver | (rx_full_flag & ~(rd_arm_q & data_read));
            overflow_flag <= ovf_set | (overflow_flag & ~(rd_arm_q & data_read));
            rd_arm_q      <= (status_read & (rx_full_flag | overflow_flag))
                           | (rd_arm_q & ~data_read);
            select_fault_flag <= fault_set
                           | (select_fault_flag & ~(flt_arm_q & control_write));
            flt_arm_q     <= (status_read & select_fault_flag)
                           | (flt_arm_q & ~control_write);
            rx_data       <= deliver ? rx_byte : rx_data;
            tx_empty_flag <= ~txq.rvalid;
            rx_err_irq    <= (rx_full_flag & rx_irq_enable & en & ~overflow_flag)
                           | (error_irq_enable & (overflow_flag | select_fault_flag));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_miso_off;
        (slv & ss_s) |=> !miso_oe;
    endproperty
    a_miso_off: assert property (p_miso_off) else $error("data out driven while deselected");

    property p_fault_gate;
        (!select_fault_enable && !select_fault_flag) |=> !select_fault_flag;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("fault set while disabled");

    property p_no_reload;
        (st_q == spi_pkg::ST_SHIFT && !edge_ev && en) |=> $stable(sh_q);
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("shift data changed mid transfer");

    property p_ovf_keep;
        (rx_full_flag && rx_done) |=> ($stable(rx_data) && overflow_flag);
    endproperty
    a_ovf_keep: assert property (p_ovf_keep) else $error("overflow lost old byte");

    property p_err_irq;
        (error_irq_enable && (overflow_flag || select_fault_flag)) |=> rx_err_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq missing");

    property p_start_lat;
        (st_q == spi_pkg::ST_IDLE && txq.rvalid && en && mst && !select_fault_flag
         && ss_s && $stable(rate))
            |-> ##[1:LAT_MAX] (st_q == spi_pkg::ST_SHIFT);
    endproperty
    a_start_lat: assert property (p_start_lat) else $error("master start too late");

    property p_sck_idle;
        (st_q == spi_pkg::ST_IDLE) |=> (serial_clock_pin_out == $past(clk_polarity_bit));
    endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock not at idle level");

    property p_rx_mask;
        (overflow_flag && !error_irq_enable) |=> !rx_err_irq;
    endproperty
    a_rx_mask: assert property (p_rx_mask) else $error("receive irq during overflow");

    c_master_done: cover property (mst && last);
    c_slave_done: cover property (slv && last && !clk_phase_bit);
    c_overflow: cover property ($rose(overflow_flag));
    c_fault: cover property ($rose(select_fault_flag));
endmodule

// ==== tb/spi_slave_model.sv ====
// behavioural serial slave answering the port in master mode
`timescale 1ns/10ps
module spi_slave_model (
    input  wire logic       sck,
    input  wire logic       idle_lvl,
    input  wire logic       phase,
    input  wire logic       mosi,
    input  wire logic       sel,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic            miso,
    output logic [7:0]      rx_byte
);
    logic [7:0] sr = 8'h00;
    logic [4:0] edges = 5'h00;
    // unselected line shows the inverse of the top bit
    assign miso = sel ? sr[7] : ~sr[7];
    always @(posedge load)
    begin
        sr = tx_byte;
        edges = 5'h00;
    end
    always @(sck)
    begin
        if (sel)
        begin
            if ((sck != idle_lvl) == !phase)
                rx_byte = {rx_byte[6:0], mosi};
            else if (!(phase && edges == 5'h00))
                sr = {sr[6:0], 1'b0};
            edges = (edges == 5'h0F) ? 5'h00 : edges + 5'h01;
        end
    end
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the serial port
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module testbench;
    logic        clk = 1'b0, rst = 1'b1, en = 1'b0, ms = 1'b1, pol = 1'b0, pha = 1'b0;
    logic        fen = 1'b0, eie = 1'b0, rie = 1'b0, txv = 1'b0, srd = 1'b0, drd = 1'b0;
    logic        cwr = 1'b0, sck_b = 1'b0, mosi_b = 1'b0, ss_n = 1'b1, load = 1'b0;
    logic [1:0]  rate = 2'h0;
    logic [7:0]  txd = 8'h00, ptx = 8'h00, rxd, p_rx;
    logic [31:0] seed = 32'hBDE57CF0;
    logic        tx_ready, rx_full, ovf, flt, tx_empty, irq, miso_m;
    logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic [7:0]  q[$];
    int          errors = 0, n_tests = 0, cyc = 0;
    wire logic   sck_w = sck_oe ? sck_o : (ms ? pol : sck_b);
    wire logic   mosi_w = mosi_oe ? mosi_o : mosi_b;
    wire logic   miso_w = miso_oe ? miso_o : miso_m;
    always #5 clk = ~clk;
    spi_port dut (
        .clk(clk), .rst(rst), .port_enable_bit(en), .master_select_bit(ms),
        .clk_polarity_bit(pol), .clk_phase_bit(pha), .rate_select_hi(rate[1]),
        .rate_select_lo(rate[0]), .select_fault_enable(fen), .error_irq_enable(eie),
        .rx_irq_enable(rie), .tx_data(txd), .tx_valid(txv), .tx_ready(tx_ready),
        .status_read(srd), .data_read(drd), .control_write(cwr), .rx_data(rxd),
        .rx_full_flag(rx_full), .overflow_flag(ovf), .select_fault_flag(flt),
        .tx_empty_flag(tx_empty), .rx_err_irq(irq), .serial_clock_pin_in(sck_w),
        .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe), .mosi_in(mosi_w),
        .mosi_out(mosi_o), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_o),
        .miso_oe(miso_oe), .ss_n_in(ss_n)
    );
    spi_slave_model partner (
        .sck(sck_w), .idle_lvl(pol), .phase(pha), .mosi(mosi_w), .sel(ms), .load(load),
        .tx_byte(ptx), .miso(miso_m), .rx_byte(p_rx)
    );
    task automatic conclude();
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            conclude();
        end
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic wr(input logic [7:0] b);
        txd = b;
        txv = 1'b1;
        tick();
        txv = 1'b0;
        tick();
    endtask
    // status read then data read
    task automatic clr();
        srd = 1'b1;
        tick();
        srd = 1'b0;
        drd = 1'b1;
        tick();
        drd = 1'b0;
        srd = 1'b1;
        tick();
        srd = 1'b0;
    endtask
    // format bits change only while the port is off
    task automatic cfg(input logic m, input logic p, input logic h, input logic [1:0] r);
        en = 1'b0;
        tick();
        {ms, pol, pha, rate, sck_b} = {m, p, h, r, p};
        tick();
        en = 1'b1;
        tick();
    endtask
    task automatic mst(input logic [7:0] b);
        int   n;
        int   h;
        logic s;
        h = 1 << (2 * rate);
        n = 0;
        ptx = rnd();
        load = 1'b1;
        tick();
        load = 1'b0;
        wr(b);
        while (sck_w === pol && n++ < 600) tick();
        `CHK(n <= 3 * h + 4, 1'b1)
        `CHK(mosi_w, b[7])
        `CHK(sck_oe & mosi_oe, 1'b1)
        s = sck_w;
        n = 0;
        while (sck_w === s && n++ < 300) tick();
        `CHK(n, h)
        n = 0;
        while (rx_full !== 1'b1 && n++ < 3000) tick();
        `CHK(rx_full, 1'b1)
        `CHK(rxd, ptx)
        `CHK(p_rx, b)
    endtask
    // bench acts as master on the pins, 80 ns link clock
    task automatic slv(input logic [7:0] mo, input logic [7:0] ex);
        logic [7:0] got;
        mosi_b = mo[7];
        #7;
        ss_n = 1'b0;
        #60;
        `CHK(miso_oe, 1'b1)
        `CHK(sck_oe | mosi_oe, 1'b0)
        if (!pha) `CHK(miso_o, ex[7])
        for (int i = 7; i >= 0; i--)
        begin
            sck_b = ~pol;
            if (pha) mosi_b = mo[i];
            #20;
            if (!pha) got[i] = miso_w;
            #20;
            sck_b = pol;
            if (!pha && i > 0) mosi_b = mo[i - 1];
            #20;
            if (pha) got[i] = miso_w;
            #20;
        end
        #80;
        ss_n = 1'b1;
        repeat (8) tick();
        `CHK(miso_oe, 1'b0)
        `CHK(got, ex)
        `CHK(rx_full, 1'b1)
        `CHK(rxd, mo)
        clr();
    endtask
    initial
    begin
        repeat (10) tick();
        rst = 1'b0;
        repeat (3) tick();
        for (int m = 0; m < 4; m++)
        begin
            cfg(1'b1, m[1], m[0], 2'h0);
            mst(rnd());
            drd = 1'b1;
            tick();
            drd = 1'b0;
            tick();
            `CHK(rx_full, 1'b1)
            clr();
            `CHK(rx_full, 1'b0)
        end
        for (int r = 0; r < 4; r++)
        begin
            cfg(1'b1, 1'b0, 1'b0, r[1:0]);
            mst(rnd());
            clr();
        end
        cfg(1'b1, 1'b0, 1'b0, 2'h0);
        rie = 1'b1;
        mst(8'hA5);
        tick();
        `CHK(irq, 1'b1)
        wr(8'h3C);
        repeat (40) tick();
        `CHK(ovf, 1'b1)
        `CHK(rxd, ptx)
        `CHK(irq, 1'b0)
        eie = 1'b1;
        repeat (2) tick();
        `CHK(irq, 1'b1)
        clr();
        `CHK(ovf, 1'b0)
        `CHK(rx_full, 1'b0)
        rie = 1'b0;
        ss_n = 1'b0;
        repeat (10) tick();
        `CHK(flt, 1'b0)
        fen = 1'b1;
        repeat (10) tick();
        `CHK(flt, 1'b1)
        `CHK(irq, 1'b1)
        ss_n = 1'b1;
        fen = 1'b0;
        repeat (5) tick();
        srd = 1'b1;
        tick();
        srd = 1'b0;
        cwr = 1'b1;
        tick();
        cwr = 1'b0;
        tick();
        `CHK(flt, 1'b0)
        eie = 1'b0;
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        while (tx_ready === 1'b1 && q.size() < 12)
        begin
            q.push_back(rnd());
            wr(q[$]);
        end
        `CHK(q.size() >= 8, 1'b1)
        wr(8'hFF);
        while (q.size() > 0)
            slv(rnd(), q.pop_front());
        `CHK(tx_empty, 1'b1)
        cfg(1'b0, 1'b1, 1'b1, 2'h0);
        wr(8'h96);
        slv(rnd(), 8'h96);
        conclude();
    end
endmodule
